// ==== src/sfr_bank_one_map.v ====
// Bank-one special function register decoder and storage behind an APB slave
//
// Implementation choice: register access over APB.
`timescale 1ns/100ps
`default_nettype none
`include "sfr_bank_one_defines.vh"

module sfr_bank_one_map
#(
   parameter REDUCED_PINS = 0,
   parameter LARGE_MEMORY = 1
)
(
   input wire ref_clk,
   input wire rst,
   input wire psel,
   input wire penable,
   input wire pwrite,
   input wire [11:0] paddr,
   input wire [31:0] pwdata,
   input wire [3:0] pstrb,
   output reg [31:0] prdata,
   output wire pready,
   output wire pslverr,
   output wire mem_req,
   output wire mem_we,
   output wire [8:0] mem_addr,
   output wire [7:0] mem_wdata,
   input wire mem_ack,
   input wire [7:0] mem_rdata,
   input wire pc_load,
   input wire [7:0] pc_load_low,
   output wire [12:0] program_counter,
   input wire reset_by_power_on,
   input wire reset_by_brown_out,
   input wire status_timeout_n,
   input wire status_powerdown_n,
   input wire [2:0] psp_status,
   input wire [5:0] serial_status,
   input wire tx_shift_empty,
   input wire [1:0] comparator_out,
   input wire [7:0] adc_result_low,
   output wire [7:0] option_config,
   output wire [7:0] port_a_direction,
   output wire [7:0] port_b_direction,
   output wire [7:0] port_c_direction,
   output wire [7:0] port_d_direction,
   output wire [7:0] port_e_direction_psp,
   output wire [7:0] interrupt_control,
   output wire [7:0] periph_irq_enable_one,
   output wire [7:0] power_control
);

   // ----------------------------------------------------------------
   // Storage
   // ----------------------------------------------------------------
   // Offsets 0x00..0x1f of bank one; 0x0f is reused for the memory
   // high address byte since that offset is unmapped in bank one.
   reg [7:0] regs [0:31];
   reg [4:0] pc_high;
   reg cause_taken;
   reg ind_done;
   integer i;

   // ----------------------------------------------------------------
   // Per-location write mask and reset value
   // ----------------------------------------------------------------
   function [7:0] wmask;
      input [4:0] off;
      begin
         case ({4'h4, off})
            `IDX_OPTION_CONFIG: wmask = `RST_ALL_ONES;
            `IDX_PC_LOW_BYTE: wmask = `RST_ALL_ONES;
            `IDX_CORE_STATUS: wmask = `WM_CORE_STATUS;
            `IDX_INDIRECT_POINTER: wmask = `RST_ALL_ONES;
            `IDX_PORT_A_DIRECTION: wmask = `WM_PORT_A_DIRECTION;
            `IDX_PORT_B_DIRECTION: wmask = `RST_ALL_ONES;
            `IDX_PORT_C_DIRECTION: wmask = `RST_ALL_ONES;
            `IDX_PORT_D_DIRECTION:
               wmask = (REDUCED_PINS != 0) ? `RST_ZERO
                       : `RST_ALL_ONES;
            `IDX_PORT_E_DIRECTION_PSP:
               wmask = (REDUCED_PINS != 0) ? `RST_ZERO
                       : `WM_PORT_E_DIRECTION_PSP;
            `IDX_PC_HIGH_LATCH: wmask = `WM_PC_HIGH_LATCH;
            `IDX_INTERRUPT_CONTROL: wmask = `RST_ALL_ONES;
            `IDX_PERIPH_IRQ_ENABLE_ONE: wmask = `RST_ALL_ONES;
            `IDX_PERIPH_IRQ_ENABLE_TWO: wmask = `WM_PERIPH_IRQ_ENABLE_TWO;
            `IDX_POWER_CONTROL: wmask = `WM_POWER_CONTROL;
            9'h08f:
               wmask = (LARGE_MEMORY != 0) ? `WM_NVM_ADDRESS_HIGH
                       : 8'h0f;
            `IDX_SYNC_SERIAL_CONTROL_TWO: wmask = `RST_ALL_ONES;
            `IDX_TIMER_TWO_PERIOD: wmask = `RST_ALL_ONES;
            `IDX_SYNC_SERIAL_ADDRESS: wmask = `RST_ALL_ONES;
            `IDX_SYNC_SERIAL_STATUS: wmask = `WM_SYNC_SERIAL_STATUS;
            `IDX_ASYNC_TX_STATUS_CONTROL: wmask = `WM_ASYNC_TX_STATUS_CONTROL;
            `IDX_BAUD_RATE_DIVISOR: wmask = `RST_ALL_ONES;
            `IDX_COMPARATOR_CONTROL: wmask = `WM_COMPARATOR_CONTROL;
            `IDX_COMPARATOR_VREF_CONTROL: wmask = `WM_COMPARATOR_VREF_CONTROL;
            `IDX_ADC_CONTROL_ONE: wmask = `WM_ADC_CONTROL_ONE;
            default: wmask = `RST_ZERO;
         endcase
      end
   endfunction

   // Bits shown as unknown at power-up reset to zero here: a defined
   // state is cheaper to verify than an undefined one.
   function [7:0] rstval;
      input [4:0] off;
      begin
         case ({4'h4, off})
            `IDX_OPTION_CONFIG: rstval = `RST_ALL_ONES;
            `IDX_PORT_A_DIRECTION: rstval = `RST_PORT_A_DIRECTION;
            `IDX_PORT_B_DIRECTION: rstval = `RST_ALL_ONES;
            `IDX_PORT_C_DIRECTION: rstval = `RST_ALL_ONES;
            `IDX_PORT_D_DIRECTION: rstval = `RST_ALL_ONES;
            `IDX_PORT_E_DIRECTION_PSP: rstval = `RST_PORT_E_DIRECTION_PSP;
            `IDX_TIMER_TWO_PERIOD: rstval = `RST_ALL_ONES;
            `IDX_COMPARATOR_CONTROL: rstval = `RST_COMPARATOR_CONTROL;
            `IDX_POWER_CONTROL: rstval = `WM_POWER_CONTROL;
            default: rstval = `RST_ZERO;
         endcase
      end
   endfunction

   // ----------------------------------------------------------------
   // Address decode
   // ----------------------------------------------------------------
   wire [8:0] idx;
   wire [1:0] bank;
   wire [4:0] off;
   wire in_window;
   wire core_loc;
   wire hit;
   wire ind_hit;
   wire setup;
   wire access;

   assign idx = paddr[10:2];
   assign bank = idx[8:7];
   assign off = idx[4:0];
   assign in_window = (paddr[11] == 1'b0) && (idx[6:5] == 2'b00);
   // Core registers answer in any bank
   assign core_loc = (off == 5'h00) || (off == 5'h02) || (off == 5'h03) ||
                     (off == 5'h04) || (off == 5'h0a) ||
                     (off == 5'h0b);
   assign hit = in_window && ((bank == 2'b01) || core_loc ||
                ((bank == 2'b10) && (off == 5'h0f)));
   assign ind_hit = hit && (off == 5'h00);
   assign setup = psel && !penable;
   assign access = psel && penable;

   // ----------------------------------------------------------------
   // Read composition
   // ----------------------------------------------------------------
   // Bank two exposes only the core registers and the memory high address byte through here.
   reg [7:0] rbits;
   always @*
   begin
      rbits = regs[off] & wmask(off);
      case (off)
         5'h03:
            rbits = rbits | {3'b000, status_timeout_n, status_powerdown_n,
                    3'b000};
         5'h09:
            if (REDUCED_PINS == 0)
            begin
               rbits = rbits | {psp_status, 5'b00000};
            end
         5'h14: rbits = rbits | {2'b00, serial_status};
         5'h18: rbits = rbits | {6'b000000, tx_shift_empty, 1'b0};
         5'h1c: rbits = rbits | {comparator_out, 6'b000000};
         5'h1e: rbits = adc_result_low;
         default: rbits = rbits;
      endcase
      if (!hit || ((bank == 2'b10) != (off == 5'h0f)) && !core_loc)
      begin
         rbits = 8'h00;
      end
   end

   // ----------------------------------------------------------------
   // APB handshake and indirect data-memory port
   // ----------------------------------------------------------------
   // Indirect transfers wait on the data memory; all others finish
   // in the first access cycle.
   assign pready = ind_hit ? ind_done : 1'b1;
   assign pslverr = 1'b0;
   assign mem_req = access && ind_hit && !ind_done;
   assign mem_we = pwrite;
   assign mem_addr = {regs[3][`STATUS_BANK_HI_BIT], regs[4]};
   assign mem_wdata = pwdata[7:0];

   wire wr_fire;
   assign wr_fire = access && pwrite && pstrb[0] && hit && !ind_hit;

   always @(posedge ref_clk or posedge rst)
   begin
      if (rst)
      begin
         prdata <= 32'h00000000;
         ind_done <= 1'b0;
      end
      else
      begin
         if (setup && !pwrite && !ind_hit)
         begin
            prdata <= {24'h000000, rbits};
         end
         if (mem_req && mem_ack)
         begin
            ind_done <= 1'b1;
            if (!pwrite)
            begin
               prdata <= {24'h000000, mem_rdata};
            end
         end
         else if (access && ind_done)
         begin
            ind_done <= 1'b0;
         end
      end
   end

   // ----------------------------------------------------------------
   // Register writes, reset-cause capture and program counter
   // ----------------------------------------------------------------
   // The cause of reset is sampled once after release, never under the
   // asynchronous reset itself.
   always @(posedge ref_clk or posedge rst)
   begin
      if (rst)
      begin
         for (i = 0; i < 32; i = i + 1)
         begin
            regs[i] <= rstval(i[4:0]);
         end
         pc_high <= 5'b00000;
         cause_taken <= 1'b0;
      end
      else
      begin
         if (!cause_taken)
         begin
            cause_taken <= 1'b1;
            regs[14][`POWER_CONTROL_POR_BIT] <= !reset_by_power_on;
            regs[14][`POWER_CONTROL_BOR_BIT] <= !reset_by_brown_out;
         end
         if (pc_load)
         begin
            regs[2] <= pc_load_low;
            pc_high <= regs[10][4:0];
         end
         if (wr_fire)
         begin
            regs[off] <= (regs[off] & ~wmask(off)) |
                         (pwdata[7:0] & wmask(off));
            if (off == 5'h02)
            begin
               pc_high <= regs[10][4:0];
            end
         end
      end
   end

   // ----------------------------------------------------------------
   // Outputs to the core and peripherals
   // ----------------------------------------------------------------
   // The counter high part has no bus location; it leaves only here.
   assign program_counter = {pc_high, regs[2]};
   assign option_config = regs[1];
   assign port_a_direction = regs[5] & `WM_PORT_A_DIRECTION;
   assign port_b_direction = regs[6];
   assign port_c_direction = regs[7];
   assign port_d_direction = regs[8] & wmask(5'h08);
   assign port_e_direction_psp = regs[9] & wmask(5'h09);
   assign interrupt_control = regs[11];
   // Reserved enable bit is passed as written; software keeps it clear
   assign periph_irq_enable_one = regs[12];
   assign power_control = regs[14] & `WM_POWER_CONTROL;

endmodule
`default_nettype wire

// ==== src/sfr_bank_one_defines.vh ====
// Offsets, field masks, reset values and field positions of the bank-one map
`ifndef SFR_BANK_ONE_DEFINES_VH
`define SFR_BANK_ONE_DEFINES_VH

// ----------------------------------------------------------------
// Register indices (byte address on the bus is four times the index)
// ----------------------------------------------------------------
`define IDX_INDIRECT_ACCESS 9'h080
`define IDX_OPTION_CONFIG 9'h081
`define IDX_PC_LOW_BYTE 9'h082
`define IDX_CORE_STATUS 9'h083
`define IDX_INDIRECT_POINTER 9'h084
`define IDX_PORT_A_DIRECTION 9'h085
`define IDX_PORT_B_DIRECTION 9'h086
`define IDX_PORT_C_DIRECTION 9'h087
`define IDX_PORT_D_DIRECTION 9'h088
`define IDX_PORT_E_DIRECTION_PSP 9'h089
`define IDX_PC_HIGH_LATCH 9'h08a
`define IDX_INTERRUPT_CONTROL 9'h08b
`define IDX_PERIPH_IRQ_ENABLE_ONE 9'h08c
`define IDX_PERIPH_IRQ_ENABLE_TWO 9'h08d
`define IDX_POWER_CONTROL 9'h08e
`define IDX_SYNC_SERIAL_CONTROL_TWO 9'h091
`define IDX_TIMER_TWO_PERIOD 9'h092
`define IDX_SYNC_SERIAL_ADDRESS 9'h093
`define IDX_SYNC_SERIAL_STATUS 9'h094
`define IDX_ASYNC_TX_STATUS_CONTROL 9'h098
`define IDX_BAUD_RATE_DIVISOR 9'h099
`define IDX_COMPARATOR_CONTROL 9'h09c
`define IDX_COMPARATOR_VREF_CONTROL 9'h09d
`define IDX_ADC_RESULT_LOW 9'h09e
`define IDX_ADC_CONTROL_ONE 9'h09f
`define IDX_NVM_ADDRESS_HIGH 9'h10f

// ----------------------------------------------------------------
// Software-writable bit masks
// ----------------------------------------------------------------
`define WM_CORE_STATUS 8'he7
`define WM_PORT_A_DIRECTION 8'h3f
`define WM_PORT_E_DIRECTION_PSP 8'h17
`define WM_PC_HIGH_LATCH 8'h1f
`define WM_PERIPH_IRQ_ENABLE_TWO 8'h59
`define WM_POWER_CONTROL 8'h03
`define WM_SYNC_SERIAL_STATUS 8'hc0
`define WM_ASYNC_TX_STATUS_CONTROL 8'hf5
`define WM_COMPARATOR_CONTROL 8'h3f
`define WM_COMPARATOR_VREF_CONTROL 8'hef
`define WM_ADC_CONTROL_ONE 8'hcf
`define WM_NVM_ADDRESS_HIGH 8'h1f

// ----------------------------------------------------------------
// Power-on / brown-out reset values of the stored bits
// ----------------------------------------------------------------
`define RST_ALL_ONES 8'hff
`define RST_ZERO 8'h00
`define RST_PORT_A_DIRECTION 8'h3f
`define RST_PORT_E_DIRECTION_PSP 8'h07
`define RST_COMPARATOR_CONTROL 8'h07

// ----------------------------------------------------------------
// Field positions
// ----------------------------------------------------------------
`define STATUS_BANK_HI_BIT 7
`define POWER_CONTROL_POR_BIT 1
`define POWER_CONTROL_BOR_BIT 0
`define NVM_ADDR_HIGH_TOP_BIT 4

`endif

// ==== sim/sfr_bank_one_check_sva.sv ====
// Port-level assertions for the bank-one register map
`timescale 1ns/100ps
`default_nettype none
module sfr_bank_one_check
(
   input wire ref_clk,
   input wire rst,
   input wire psel,
   input wire penable,
   input wire pwrite,
   input wire [11:0] paddr,
   input wire [31:0] pwdata,
   input wire [3:0] pstrb,
   input wire [31:0] prdata,
   input wire pready,
   input wire pslverr,
   input wire mem_req,
   input wire mem_we,
   input wire [7:0] mem_wdata,
   input wire mem_ack,
   input wire pc_load,
   input wire [7:0] pc_load_low,
   input wire [12:0] program_counter,
   input wire reset_by_power_on,
   input wire reset_by_brown_out,
   input wire [7:0] power_control,
   input wire [7:0] port_a_direction
);
   default clocking cb @(posedge ref_clk); endclocking
   default disable iff (rst);
   // ----------------------------------------------------------------
   // Bus phases
   // ----------------------------------------------------------------
   sequence setup_rd;
      psel && !penable && !pwrite;
   endsequence
   sequence wr_done;
      psel && penable && pready && pwrite && pstrb[0];
   endsequence
   sequence ind_wait;
      mem_req && !mem_ack;
   endsequence
   // ----------------------------------------------------------------
   // Properties
   // ----------------------------------------------------------------
   a_no_slave_err:
      assert property (!pslverr && prdata[31:8] == 24'h000000)
      else $error("error response or upper read bits set");
   a_unmapped_zero:
      assert property (setup_rd ##0 (paddr[10:2] == 9'h08f) |=> prdata == 0)
      else $error("unimplemented location read nonzero");
   a_dir_mask:
      assert property (wr_done ##0 (paddr[10:2] == 9'h085) |=>
         port_a_direction == ($past(pwdata[7:0]) & 8'h3f))
      else $error("port a direction write mask wrong");
   a_pc_low_load:
      assert property (pc_load && !(psel && penable && pwrite) |=>
         program_counter[7:0] == $past(pc_load_low))
      else $error("counter low byte not loaded");
   a_pc_high_hold:
      assert property (!pc_load && !(psel && penable && pwrite) |=>
         $stable(program_counter[12:8]))
      else $error("counter high part changed without load");
   a_direct_ready:
      assert property (psel && penable && paddr[8:2] != 7'h00 |-> pready)
      else $error("plain register access stalled");
   a_wait_request:
      assert property (psel && penable && !pready |-> mem_req)
      else $error("indirect stall without memory request");
   a_req_hold:
      assert property (ind_wait |=> mem_req)
      else $error("memory request dropped before acknowledge");
   a_ack_done:
      assert property (mem_req && mem_ack |=> pready && !mem_req)
      else $error("indirect transfer not completed after acknowledge");
   a_mem_data:
      assert property (mem_req |-> mem_we == pwrite &&
         mem_wdata == pwdata[7:0])
      else $error("memory request direction or data wrong");
   a_cause_capture:
      assert property ($fell(rst) |=> power_control == {6'h00,
         !$past(reset_by_power_on), !$past(reset_by_brown_out)})
      else $error("reset cause bits not captured");
endmodule
`default_nettype wire

// ==== sim/sfr_bank_one_map_test.sv ====
// Self-checking bench for the bank-one register map
`timescale 1ns/100ps
`default_nettype none
module sfr_bank_one_map_test;
   logic ref_clk = 1'b0;
   logic rst = 1'b0;
   logic psel = 1'b0, penable = 1'b0, pwrite = 1'b0, pc_load = 1'b0;
   logic [11:0] paddr = 12'h000;
   logic [31:0] pwdata = 32'h0;
   logic [3:0] pstrb = 4'hf;
   logic mem_ack = 1'b0, por_cause = 1'b1, bor_cause = 1'b0;
   logic [7:0] mem_rdata = 8'h00, pc_load_low = 8'h00, mem_last = 8'h00;
   logic [7:0] adc_low = 8'h00, v;
   wire [31:0] prdata;
   wire pready, pslverr, mem_req, mem_we;
   wire [8:0] mem_addr;
   wire [7:0] mem_wdata, option_config, port_a_direction, power_control;
   wire [12:0] program_counter;
   int mismatches = 0;
   int checks = 0;
   // Reset values and write masks, packed as {index, value}
   logic [16:0] rst_tab [14] = '{{9'h081, 8'hff}, {9'h082, 8'h00},
      {9'h083, 8'h18}, {9'h085, 8'h3f}, {9'h086, 8'hff}, {9'h087, 8'hff},
      {9'h088, 8'hff}, {9'h089, 8'h07}, {9'h08a, 8'h00}, {9'h08c, 8'h00},
      {9'h092, 8'hff}, {9'h098, 8'h02}, {9'h09c, 8'h07}, {9'h09f, 8'h00}};
   logic [16:0] mask_tab [12] = '{{9'h085, 8'h3f}, {9'h089, 8'h17},
      {9'h08a, 8'h1f}, {9'h08d, 8'h59}, {9'h094, 8'hc0}, {9'h098, 8'hf7},
      {9'h09c, 8'h3f}, {9'h09d, 8'hef}, {9'h09f, 8'hcf}, {9'h08f, 8'h00},
      {9'h090, 8'h00}, {9'h09b, 8'h00}};
   sfr_bank_one_map dut (.ref_clk(ref_clk), .rst(rst), .psel(psel),
      .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
      .pstrb(pstrb), .prdata(prdata), .pready(pready), .pslverr(pslverr),
      .mem_req(mem_req), .mem_we(mem_we), .mem_addr(mem_addr),
      .mem_wdata(mem_wdata), .mem_ack(mem_ack), .mem_rdata(mem_rdata),
      .pc_load(pc_load), .pc_load_low(pc_load_low),
      .program_counter(program_counter), .reset_by_power_on(por_cause),
      .reset_by_brown_out(bor_cause), .status_timeout_n(por_cause),
      .status_powerdown_n(por_cause), .psp_status(adc_low[2:0]),
      .serial_status(adc_low[5:0]), .tx_shift_empty(por_cause),
      .comparator_out(adc_low[1:0]), .adc_result_low(adc_low),
      .option_config(option_config), .port_a_direction(port_a_direction),
      .port_b_direction(), .port_c_direction(), .port_d_direction(),
      .port_e_direction_psp(), .interrupt_control(),
      .periph_irq_enable_one(), .power_control(power_control));
   always #4 ref_clk = ~ref_clk;
   // Data memory stand-in: one wait state, data unlike the last outside ack
   always @(posedge ref_clk)
   begin
      mem_ack <= mem_req && !mem_ack;
      mem_rdata <= mem_req ? ~mem_addr[7:0] : ~mem_rdata;
      if (mem_req && mem_ack && mem_we)
         mem_last <= mem_wdata;
   end
   task automatic end_of_test();
      $display("checks %0d mismatches %0d", checks, mismatches);
      if (mismatches == 0 && checks > 0)
         $display("TB: PASS");
      else
         $display("TB: FAIL");
      $finish;
   endtask
   task automatic cmp(input string what, input logic [15:0] exp,
      input logic [15:0] got);
      checks++;
      if (got !== exp)
      begin
         mismatches++;
         $display("[ERR] %s expected %h seen %h", what, exp, got);
      end
   endtask
   task automatic apb(input logic wr, input logic [8:0] idx,
      input logic [7:0] wd);
      int n;
      n = 0;
      psel <= 1'b1;
      pwrite <= wr;
      paddr <= {1'b0, idx, 2'b00};
      pwdata <= {24'h0, wd};
      @(posedge ref_clk);
      penable <= 1'b1;
      do
      begin
         @(posedge ref_clk);
         n++;
      end
      while (pready !== 1'b1 && n < 50);
      if (n >= 50)
      begin
         mismatches++;
         end_of_test();
      end
      v = prdata[7:0];
      psel <= 1'b0;
      penable <= 1'b0;
      @(posedge ref_clk);
   endtask
   task automatic rd(input logic [8:0] idx, input logic [7:0] exp);
      apb(1'b0, idx, 8'h00);
      cmp($sformatf("reg %h", idx), {8'h00, exp}, {8'h00, v});
   endtask
   initial
   begin
      // A real rising edge on reset, so the asynchronous branch runs
      rst <= 1'b1;
      repeat (16) @(posedge ref_clk);
      rst <= 1'b0;
      @(posedge ref_clk);
      foreach (rst_tab[i]) rd(rst_tab[i][16:8], rst_tab[i][7:0]);
      rd(9'h08e, 8'h01);
      cmp("option out", 16'h00ff, {8'h00, option_config});
      foreach (mask_tab[i])
      begin
         apb(1'b1, mask_tab[i][16:8], 8'hff);
         rd(mask_tab[i][16:8], mask_tab[i][7:0]);
      end
      // Software keeps the reserved parallel slave enable bit clear
      apb(1'b1, 9'h08c, 8'h7f);
      rd(9'h08c, 8'h7f);
      pstrb <= 4'he;
      apb(1'b1, 9'h085, 8'h00);
      pstrb <= 4'hf;
      rd(9'h085, 8'h3f);
      apb(1'b1, 9'h10f, 8'hff);
      rd(9'h10f, 8'h1f);
      apb(1'b1, 9'h10a, 8'h0b);
      rd(9'h00a, 8'h0b);
      rd(9'h18a, 8'h0b);
      pc_load <= 1'b1;
      pc_load_low <= 8'h3c;
      @(posedge ref_clk);
      pc_load <= 1'b0;
      @(posedge ref_clk);
      cmp("counter", 16'h0b3c, {3'h0, program_counter});
      apb(1'b1, 9'h082, 8'h77);
      apb(1'b1, 9'h08a, 8'h1f);
      cmp("counter", 16'h0b77, {3'h0, program_counter});
      rd(9'h082, 8'h77);
      apb(1'b1, 9'h184, 8'h5a);
      rd(9'h084, 8'h5a);
      rd(9'h080, 8'ha5);
      rd(9'h100, 8'ha5);
      apb(1'b1, 9'h180, 8'hc3);
      cmp("memory write", 16'h00c3, {8'h00, mem_last});
      adc_low <= 8'h96;
      rd(9'h09e, 8'h96);
      end_of_test();
   end
endmodule
bind sfr_bank_one_map sfr_bank_one_check chk (.ref_clk, .rst, .psel,
   .penable, .pwrite, .paddr, .pwdata, .pstrb, .prdata, .pready, .pslverr,
   .mem_req, .mem_we, .mem_wdata, .mem_ack, .pc_load, .pc_load_low,
   .program_counter, .reset_by_power_on, .reset_by_brown_out,
   .power_control, .port_a_direction);
`default_nettype wire
